// ===== verilog/slfc_defs.svh
// timing, field and reset constants of the serial line frame port
`ifndef SLFC_DEFS_SVH
`define SLFC_DEFS_SVH

`define SLFC_CLK_HZ     50000000
`define SLFC_BAUD_LO    9600
`define SLFC_BAUD_HI    19200
`define SLFC_DIV_LO     (`SLFC_CLK_HZ / `SLFC_BAUD_LO)
`define SLFC_DIV_HI     (`SLFC_CLK_HZ / `SLFC_BAUD_HI)
`define SLFC_DIV_W      13
`define SLFC_DATA_BITS  8
`define SLFC_LAST_BIT   3'h7
`define SLFC_ADDR_MIN   8'h01
`define SLFC_ADDR_MAX   8'hF7
`define SLFC_RST_ADDR   8'h01
`define SLFC_RST_BAUDHI 1'b0
`define SLFC_RST_PAR    2'h1
`define SLFC_RST_FOURW  1'b0
`define SLFC_GAP_BITS   39
`define SLFC_GAP_W      20

`endif

// ===== verilog/slfc_pkg.sv
// types shared by the serial line frame port
package slfc_pkg;
   typedef enum logic [1:0] {
      PAR_NONE = 2'h0,
      PAR_EVEN = 2'h1,
      PAR_ODD  = 2'h2
   } slfc_parity_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_DATA  = 3'h3,
      ST_PAR   = 3'h2,
      ST_STOP  = 3'h6
   } slfc_state_e;
endpackage : slfc_pkg

// ===== verilog/slfc_baud_tick.sv
// bit period counter giving mid-bit and end-of-bit ticks
`timescale 1ns/1ps
module slfc_baud_tick #(
   parameter int W = 13
) (
   input  wire logic         clk,      // system clock
   input  wire logic         rstn,     // synchronous reset, active low
   input  wire logic         clkEn,    // freezes the counter while low
   input  wire logic         run,      // counts while high, clears while low
   input  wire logic [W-1:0] div,      // clocks per bit
   output logic              midTick,  // middle of the bit
   output logic              endTick   // last clock of the bit
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb begin
      if (!run || endTick) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else if (clkEn) begin
         cnt_r <= cnt_nxt;
      end
   end

   assign midTick = run && (cnt_r == (div >> 1));
   assign endTick = run && (cnt_r == div - W'(1));
endmodule : slfc_baud_tick

// ===== verilog/slfc_serial_port.sv
// serial line character framing and configuration of a field-bus slave port
`timescale 1ns/1ps
`include "slfc_defs.svh"
module slfc_serial_port #(
   parameter int DIV_LO   = `SLFC_DIV_LO,   // clocks per bit at the low rate
   parameter int DIV_HI   = `SLFC_DIV_HI,   // clocks per bit at the high rate
   parameter int GAP_BITS = `SLFC_GAP_BITS  // idle bit times that end a frame
) (
   input  wire logic       clk,         // system clock, 50 MHz
   input  wire logic       rstn,        // synchronous reset, active low
   input  wire logic       clkEn,       // freezes all state while low
   input  wire logic       cfgBaudHi,   // staged rate: 1 = high rate
   input  wire logic [1:0] cfgParity,   // staged parity mode
   input  wire logic       cfgFourWire, // staged wiring: 1 = full duplex
   input  wire logic [7:0] cfgAddr,     // staged slave address
   input  wire logic       cfgWrite,    // stores the staged settings
   input  wire logic       restart,     // applies staged settings, aborts traffic
   output logic            cfgReject,   // write refused, one cycle
   output logic            actBaudHi,   // rate in use
   output logic [1:0]      actParity,   // parity in use
   output logic            actFourWire, // wiring in use
   output logic [7:0]      actAddr,     // address in use
   input  wire logic [7:0] txData,      // character to send
   input  wire logic       txValid,     // character offered
   output logic            txReady,     // character taken when valid
   output logic [7:0]      rxData,      // received character
   output logic            rxValid,     // received character good, one cycle
   output logic            rxFirst,     // character opens a frame
   output logic            rxErr,       // sticky line error
   input  wire logic       errClr,      // clears the error flag
   input  wire logic       lineRx,      // receive line level
   output logic            lineTx,      // transmit line level
   output logic            lineTxOe     // driver enable, high while driving
);
   localparam logic [`SLFC_GAP_W-1:0] GapW = `SLFC_GAP_W'(GAP_BITS);

   // configuration: staged copy and the copy in use
   logic       stBaud_r, stBaud_nxt, stFour_r, stFour_nxt, rej_r, rej_nxt;
   logic       aBaud_nxt, aFour_nxt, cfgOk;
   logic [1:0] stPar_r, stPar_nxt, aPar_nxt;
   logic [7:0] stAddr_r, stAddr_nxt, aAddr_nxt;

   assign cfgOk = (cfgAddr >= `SLFC_ADDR_MIN) && (cfgAddr <= `SLFC_ADDR_MAX)
                  && (cfgParity != 2'h3);

   always_comb begin
      stBaud_nxt = stBaud_r;
      stPar_nxt  = stPar_r;
      stFour_nxt = stFour_r;
      stAddr_nxt = stAddr_r;
      aBaud_nxt  = actBaudHi;
      aPar_nxt   = actParity;
      aFour_nxt  = actFourWire;
      aAddr_nxt  = actAddr;
      rej_nxt    = cfgWrite && !cfgOk;
      if (cfgWrite && cfgOk) begin
         stBaud_nxt = cfgBaudHi;
         stPar_nxt  = cfgParity;
         stFour_nxt = cfgFourWire;
         stAddr_nxt = cfgAddr;
      end
      if (restart) begin
         aBaud_nxt = stBaud_r;
         aPar_nxt  = stPar_r;
         aFour_nxt = stFour_r;
         aAddr_nxt = stAddr_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stBaud_r    <= `SLFC_RST_BAUDHI;
         stPar_r     <= `SLFC_RST_PAR;
         stFour_r    <= `SLFC_RST_FOURW;
         stAddr_r    <= `SLFC_RST_ADDR;
         actBaudHi   <= `SLFC_RST_BAUDHI;
         actParity   <= `SLFC_RST_PAR;
         actFourWire <= `SLFC_RST_FOURW;
         actAddr     <= `SLFC_RST_ADDR;
         rej_r       <= 1'b0;
      end else if (clkEn) begin
         stBaud_r    <= stBaud_nxt;
         stPar_r     <= stPar_nxt;
         stFour_r    <= stFour_nxt;
         stAddr_r    <= stAddr_nxt;
         actBaudHi   <= aBaud_nxt;
         actParity   <= aPar_nxt;
         actFourWire <= aFour_nxt;
         actAddr     <= aAddr_nxt;
         rej_r       <= rej_nxt;
      end
   end
   assign cfgReject = rej_r;

   logic [`SLFC_DIV_W-1:0] div;
   logic                   parOn, parOdd;
   assign div    = actBaudHi ? `SLFC_DIV_W'(DIV_HI) : `SLFC_DIV_W'(DIV_LO);
   assign parOn  = actParity != slfc_pkg::PAR_NONE;
   assign parOdd = actParity == slfc_pkg::PAR_ODD;

   // transmitter
   slfc_pkg::slfc_state_e txSt_r, txSt_nxt, rxSt_r, rxSt_nxt;
   logic [7:0] txShift_r, txShift_nxt;
   logic [2:0] txCnt_r, txCnt_nxt;
   logic       txPar_r, txPar_nxt, txLine_nxt, txEnd, rxMid, rxEnd, txTake;

   slfc_baud_tick #(.W(`SLFC_DIV_W)) u_txTick (
      .clk     (clk),
      .rstn    (rstn),
      .clkEn   (clkEn),
      .run     (txSt_r != slfc_pkg::ST_IDLE),
      .div     (div),
      .midTick (),
      .endTick (txEnd)
   );

   // two wires: no send while a character is arriving
   assign txReady = (txSt_r == slfc_pkg::ST_IDLE) && !restart
                    && (actFourWire || rxSt_r == slfc_pkg::ST_IDLE);
   assign txTake  = txValid && txReady;

   always_comb begin
      txSt_nxt    = txSt_r;
      txShift_nxt = txShift_r;
      txCnt_nxt   = txCnt_r;
      txPar_nxt   = txPar_r;
      if (restart) begin
         txSt_nxt = slfc_pkg::ST_IDLE;
      end else begin
         case (txSt_r)
            slfc_pkg::ST_IDLE: if (txTake) begin
               txSt_nxt    = slfc_pkg::ST_START;
               txShift_nxt = txData;
               txCnt_nxt   = 3'h0;
               txPar_nxt   = (^txData) ^ parOdd;
            end
            slfc_pkg::ST_START: if (txEnd) begin
               txSt_nxt = slfc_pkg::ST_DATA;
            end
            slfc_pkg::ST_DATA: if (txEnd) begin
               txShift_nxt = {1'b0, txShift_r[7:1]};
               txCnt_nxt   = txCnt_r + 3'h1;
               if (txCnt_r == `SLFC_LAST_BIT) begin
                  txSt_nxt = parOn ? slfc_pkg::ST_PAR : slfc_pkg::ST_STOP;
               end
            end
            slfc_pkg::ST_PAR: if (txEnd) begin
               txSt_nxt = slfc_pkg::ST_STOP;
            end
            slfc_pkg::ST_STOP: if (txEnd) begin
               if (!parOn && txCnt_r == 3'h0) begin
                  txCnt_nxt = 3'h1;
               end else begin
                  txSt_nxt = slfc_pkg::ST_IDLE;
               end
            end
            default: txSt_nxt = slfc_pkg::ST_IDLE;
         endcase
      end
      case (txSt_nxt)
         slfc_pkg::ST_START: txLine_nxt = 1'b0;
         slfc_pkg::ST_DATA:  txLine_nxt = txShift_nxt[0];
         slfc_pkg::ST_PAR:   txLine_nxt = txPar_nxt;
         default:            txLine_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         txSt_r    <= slfc_pkg::ST_IDLE;
         txShift_r <= 8'h00;
         txCnt_r   <= 3'h0;
         txPar_r   <= 1'b0;
         lineTx    <= 1'b1;
      end else if (clkEn) begin
         txSt_r    <= txSt_nxt;
         txShift_r <= txShift_nxt;
         txCnt_r   <= txCnt_nxt;
         txPar_r   <= txPar_nxt;
         lineTx    <= txLine_nxt;
      end
   end
   // two wires: release the shared pair between characters
   assign lineTxOe = actFourWire || (txSt_r != slfc_pkg::ST_IDLE);

   // receiver
   logic [7:0]             rxShift_r, rxShift_nxt, rxData_nxt;
   logic [2:0]             rxCnt_r, rxCnt_nxt;
   logic [`SLFC_GAP_W-1:0] gap_r, gap_nxt, gapLimit;
   logic rxBad_r, rxBad_nxt, rxDone, rxBadNow, rxGo;
   logic rxValid_nxt, rxFirst_nxt, rxErr_nxt, drop_r, drop_nxt, open_r, open_nxt;

   slfc_baud_tick #(.W(`SLFC_DIV_W)) u_rxTick (
      .clk     (clk),
      .rstn    (rstn),
      .clkEn   (clkEn),
      .run     (rxSt_r != slfc_pkg::ST_IDLE),
      .div     (div),
      .midTick (rxMid),
      .endTick (rxEnd)
   );

   assign gapLimit = `SLFC_GAP_W'(div * GapW);
   assign rxGo     = (rxSt_r == slfc_pkg::ST_IDLE) && !lineRx && !restart
                     && (actFourWire || (txSt_r == slfc_pkg::ST_IDLE && !txTake));
   assign rxBadNow = rxBad_r || !lineRx;
   assign rxDone   = (rxSt_r == slfc_pkg::ST_STOP) && rxMid && !restart
                     && (parOn || rxCnt_r != 3'h0);

   always_comb begin
      rxSt_nxt    = rxSt_r;
      rxShift_nxt = rxShift_r;
      rxCnt_nxt   = rxCnt_r;
      rxBad_nxt   = rxBad_r;
      rxData_nxt  = rxData;
      rxValid_nxt = 1'b0;
      rxFirst_nxt = rxFirst;
      drop_nxt    = drop_r;
      open_nxt    = open_r;
      rxErr_nxt   = rxErr && !errClr;
      gap_nxt     = (rxSt_r != slfc_pkg::ST_IDLE || !lineRx) ? '0 :
                    (gap_r == gapLimit) ? gap_r : gap_r + `SLFC_GAP_W'(1);
      if (gap_r == gapLimit) begin
         open_nxt = 1'b0;
         drop_nxt = 1'b0;
      end
      if (restart) begin
         rxSt_nxt = slfc_pkg::ST_IDLE;
         open_nxt = 1'b0;
         drop_nxt = 1'b0;
      end else begin
         case (rxSt_r)
            slfc_pkg::ST_IDLE: if (rxGo) begin
               rxSt_nxt  = slfc_pkg::ST_START;
               rxCnt_nxt = 3'h0;
               rxBad_nxt = 1'b0;
            end
            slfc_pkg::ST_START: begin
               if (rxMid && lineRx) begin
                  rxSt_nxt = slfc_pkg::ST_IDLE;
               end else if (rxEnd) begin
                  rxSt_nxt = slfc_pkg::ST_DATA;
               end
            end
            slfc_pkg::ST_DATA: begin
               if (rxMid) begin
                  rxShift_nxt = {lineRx, rxShift_r[7:1]};
               end
               if (rxEnd) begin
                  rxCnt_nxt = rxCnt_r + 3'h1;
                  if (rxCnt_r == `SLFC_LAST_BIT) begin
                     rxSt_nxt = parOn ? slfc_pkg::ST_PAR : slfc_pkg::ST_STOP;
                  end
               end
            end
            slfc_pkg::ST_PAR: begin
               if (rxMid && (lineRx != ((^rxShift_r) ^ parOdd))) begin
                  rxBad_nxt = 1'b1;
               end
               if (rxEnd) begin
                  rxSt_nxt = slfc_pkg::ST_STOP;
               end
            end
            slfc_pkg::ST_STOP: begin
               if (rxMid && !lineRx) begin
                  rxBad_nxt = 1'b1;
               end
               if (rxDone) begin
                  rxSt_nxt = slfc_pkg::ST_IDLE;
               end else if (rxEnd) begin
                  rxCnt_nxt = 3'h1;
               end
            end
            default: rxSt_nxt = slfc_pkg::ST_IDLE;
         endcase
      end
      if (rxDone) begin
         open_nxt = 1'b1;
         if (rxBadNow) begin
            rxErr_nxt = 1'b1;
            drop_nxt  = 1'b1;
         end else if (!drop_r) begin
            rxValid_nxt = 1'b1;
            rxData_nxt  = rxShift_r;
            rxFirst_nxt = !open_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxSt_r    <= slfc_pkg::ST_IDLE;
         rxShift_r <= 8'h00;
         rxCnt_r   <= 3'h0;
         rxBad_r   <= 1'b0;
         rxData    <= 8'h00;
         rxValid   <= 1'b0;
         rxFirst   <= 1'b0;
         rxErr     <= 1'b0;
         drop_r    <= 1'b0;
         open_r    <= 1'b0;
         gap_r     <= '0;
      end else if (clkEn) begin
         rxSt_r    <= rxSt_nxt;
         rxShift_r <= rxShift_nxt;
         rxCnt_r   <= rxCnt_nxt;
         rxBad_r   <= rxBad_nxt;
         rxData    <= rxData_nxt;
         rxValid   <= rxValid_nxt;
         rxFirst   <= rxFirst_nxt;
         rxErr     <= rxErr_nxt;
         drop_r    <= drop_nxt;
         open_r    <= open_nxt;
         gap_r     <= gap_nxt;
      end
   end

   // checks
   logic [`SLFC_DIV_W-1:0] startLen_r;
   always_ff @(posedge clk) begin
      if (!rstn || txSt_r != slfc_pkg::ST_START) begin
         startLen_r <= '0;
      end else if (clkEn) begin
         startLen_r <= startLen_r + `SLFC_DIV_W'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_startLen;
      txSt_r == slfc_pkg::ST_START && txEnd && clkEn && !restart
         |-> startLen_r == div - `SLFC_DIV_W'(1);
   endproperty
   a_startLen: assert property (p_startLen) else $error("start bit length wrong");
   property p_eightBits;
      txSt_r == slfc_pkg::ST_DATA && txEnd && clkEn && !restart && txCnt_r == 3'h7
         |=> txSt_r != slfc_pkg::ST_DATA;
   endproperty
   a_eightBits: assert property (p_eightBits) else $error("data bit count wrong");
   property p_parBit;
      txSt_r == slfc_pkg::ST_PAR |-> lineTx == txPar_r;
   endproperty
   a_parBit: assert property (p_parBit) else $error("parity bit not on line");
   property p_parStop;
      txSt_r == slfc_pkg::ST_STOP && txEnd && clkEn && !restart && !parOn && txCnt_r == 3'h0
         |=> txSt_r == slfc_pkg::ST_STOP && lineTx;
   endproperty
   a_parStop: assert property (p_parStop) else $error("second stop bit missing");
   property p_addrRange;
      cfgWrite && clkEn && (cfgAddr == 8'h00 || cfgAddr > 8'hF7)
         |=> cfgReject && stAddr_r == $past(stAddr_r);
   endproperty
   a_addrRange: assert property (p_addrRange) else $error("bad address accepted");
   property p_defaults;
      $rose(rstn) |-> actParity == slfc_pkg::PAR_EVEN && !actBaudHi && actAddr == 8'h01;
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults wrong after reset");
   property p_noEarly;
      !restart ##1 !restart |-> actAddr == $past(actAddr) && actParity == $past(actParity);
   endproperty
   a_noEarly: assert property (p_noEarly) else $error("settings changed early");
   property p_halfDuplex;
      !actFourWire && txSt_r != slfc_pkg::ST_IDLE |-> rxSt_r == slfc_pkg::ST_IDLE;
   endproperty
   a_halfDuplex: assert property (p_halfDuplex) else $error("tx and rx overlap");
   property p_errDrop;
      rxDone && rxBadNow && clkEn |=> rxErr && !rxValid;
   endproperty
   a_errDrop: assert property (p_errDrop) else $error("bad character not flagged");
endmodule : slfc_serial_port

// ===== verif/slfc_bus_master.sv
// bus master model: sends characters to the port and receives its replies
`timescale 1ns/1ps
module slfc_bus_master (
   input  wire logic clk,    // system clock
   input  wire logic lineIn, // level the master hears
   output logic      mTx,    // master drive level
   output logic      mOe     // high while the master drives
);
   initial begin
      mTx = 1'b1;
      mOe = 1'b0;
   end

   task automatic bitOut(input logic b, input int div);
      mTx <= b;
      repeat (div) @(posedge clk);
   endtask : bitOut

   // call just after a rising edge; flip spoils the parity bit
   task automatic send(input logic [7:0] d, input logic [1:0] par, input int div,
                       input logic flip);
      int i;
      mOe <= 1'b1;
      bitOut(1'b0, div);
      for (i = 0; i < 8; i++) bitOut(d[i], div);
      if (par != 2'h0) bitOut((^d) ^ (par == 2'h2) ^ flip, div);
      bitOut(1'b1, div);
      if (par == 2'h0) bitOut(1'b1, div);
      mOe <= 1'b0;
   endtask : send

   // samples each bit at its middle; ok drops on a bad start, parity or stop
   task automatic recv(input logic [1:0] par, input int div, output logic [7:0] d,
                       output logic ok);
      int i;
      i = 0;
      #1;
      while (lineIn !== 1'b0 && i < 40 * div) begin
         @(posedge clk);
         #1;
         i++;
      end
      repeat (div / 2) @(posedge clk);
      #1;
      ok = (lineIn === 1'b0);
      for (i = 0; i < 8; i++) begin
         repeat (div) @(posedge clk);
         #1;
         d[i] = lineIn;
      end
      if (par != 2'h0) begin
         repeat (div) @(posedge clk);
         #1;
         if (lineIn !== ((^d) ^ (par == 2'h2))) ok = 1'b0;
      end
      for (i = 0; i < ((par == 2'h0) ? 2 : 1); i++) begin
         repeat (div) @(posedge clk);
         #1;
         if (lineIn !== 1'b1) ok = 1'b0;
      end
   endtask : recv
endmodule : slfc_bus_master

// ===== verif/slfc_serial_port_tb.sv
// self-checking bench of the serial line frame port
`timescale 1ns/1ps
`define SLFC_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD %0t mismatch at line %0d", $time, `__LINE__); end end
module slfc_serial_port_tb;
   localparam int DLO = 16;
   localparam int DHI = 8;
   localparam int GAP = 4;
   logic       clk = 1'b0;
   logic       rstn, cfgBaudHi, cfgFourWire, cfgWrite, restart, txValid, errClr, clkEn;
   logic [1:0] cfgParity, actParity;
   logic [7:0] cfgAddr, txData, actAddr, rxData, gotData;
   logic       cfgReject, actBaudHi, actFourWire, txReady, rxValid, rxFirst, rxErr;
   logic       lineTx, lineTxOe, mTx, mOe, fourW, gotFirst;
   wire        lineRx, mHear;
   int         mismatches = 0;
   int         checks_done = 0;
   int         gotCnt = 0;
   int         i;
   logic       hiT [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic [1:0] parT [4] = '{2'h2, 2'h0, 2'h0, 2'h1};
   logic       fourT [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

   // two-wire: the port hears its own drive; a released pair is biased high
   assign lineRx = (fourW || lineTxOe !== 1'b1) ? (mOe ? mTx : 1'b1) : lineTx;
   assign mHear  = (lineTxOe === 1'b1) ? lineTx : 1'b1;

   always #10 clk = ~clk;

   slfc_serial_port #(.DIV_LO(DLO), .DIV_HI(DHI), .GAP_BITS(GAP)) u_dut (
      .clk(clk), .rstn(rstn), .clkEn(clkEn), .cfgBaudHi(cfgBaudHi),
      .cfgParity(cfgParity), .cfgFourWire(cfgFourWire), .cfgAddr(cfgAddr),
      .cfgWrite(cfgWrite), .restart(restart), .cfgReject(cfgReject),
      .actBaudHi(actBaudHi), .actParity(actParity), .actFourWire(actFourWire),
      .actAddr(actAddr), .txData(txData), .txValid(txValid), .txReady(txReady),
      .rxData(rxData), .rxValid(rxValid), .rxFirst(rxFirst), .rxErr(rxErr),
      .errClr(errClr), .lineRx(lineRx), .lineTx(lineTx), .lineTxOe(lineTxOe)
   );

   slfc_bus_master u_master (.clk(clk), .lineIn(mHear), .mTx(mTx), .mOe(mOe));

   always @(posedge clk) begin
      if (rxValid === 1'b1) begin
         gotCnt   <= gotCnt + 1;
         gotData  <= rxData;
         gotFirst <= rxFirst;
      end
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   task automatic setCfg(input logic hi, input logic [1:0] par, input logic four,
                         input logic [7:0] addr, input logic rej);
      @(posedge clk);
      cfgBaudHi   <= hi;
      cfgParity   <= par;
      cfgFourWire <= four;
      cfgAddr     <= addr;
      cfgWrite    <= 1'b1;
      @(posedge clk);
      cfgWrite <= 1'b0;
      #1;
      `SLFC_CHK(cfgReject, rej)
   endtask : setCfg

   task automatic restartChk(input logic hi, input logic [1:0] par, input logic four,
                             input logic [7:0] addr);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      fourW   <= four;
      #1;
      `SLFC_CHK({actBaudHi, actParity, actFourWire, actAddr}, {hi, par, four, addr})
   endtask : restartChk

   task automatic txChar(input logic [7:0] d, input logic [1:0] par, input int div);
      int n;
      logic [7:0] got;
      logic ok;
      n = 0;
      @(posedge clk);
      txData  <= d;
      txValid <= 1'b1;
      @(posedge clk);
      txValid <= 1'b0;
      fork
         u_master.recv(par, div, got, ok);
         begin
            #1;
            `SLFC_CHK(lineTxOe, 1'b1)
            while (txReady !== 1'b1 && n < 20 * div) begin
               @(posedge clk);
               #1;
               n++;
            end
         end
      join
      `SLFC_CHK(got, d)
      `SLFC_CHK(ok, 1'b1)
      n = n - (9 + int'(par != 2'h0) + (par == 2'h0 ? 2 : 1)) * div;
      `SLFC_CHK(n >= -1 && n <= 1, 1'b1)
      `SLFC_CHK(lineTxOe, fourW)
   endtask : txChar

   task automatic rxChar(input logic [7:0] d, input logic [1:0] par, input int div,
                         input logic flip, input logic good);
      int c0;
      c0 = gotCnt;
      @(posedge clk);
      u_master.send(d, par, div, flip);
      repeat (2) @(posedge clk);
      #1;
      `SLFC_CHK(gotCnt == c0 + int'(good), 1'b1)
      if (good) `SLFC_CHK(gotData, d)
   endtask : rxChar

   initial begin
      {rstn, cfgBaudHi, cfgFourWire, cfgWrite, restart, txValid, errClr} = 7'h00;
      {cfgParity, cfgAddr, txData} = 18'h00000;
      fourW = 1'b0;
      clkEn = 1'b1;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `SLFC_CHK({actBaudHi, actParity, actFourWire, actAddr}, 12'h201)
      `SLFC_CHK({lineTx, lineTxOe, txReady, rxErr}, 4'hA)
      $display("test reset done");
      setCfg(1'b0, 2'h1, 1'b0, 8'h00, 1'b1);
      setCfg(1'b0, 2'h1, 1'b0, 8'hF8, 1'b1);
      setCfg(1'b0, 2'h3, 1'b0, 8'h05, 1'b1);
      setCfg(1'b1, 2'h2, 1'b1, 8'hF7, 1'b0);
      setCfg(1'b0, 2'h1, 1'b0, 8'h00, 1'b1);
      `SLFC_CHK({actBaudHi, actParity, actFourWire, actAddr}, 12'h201)
      restartChk(1'b1, 2'h2, 1'b1, 8'hF7);
      $display("test config done");
      for (i = 0; i < 4; i++) begin
         setCfg(hiT[i], parT[i], fourT[i], 8'h10 + 8'(i), 1'b0);
         restartChk(hiT[i], parT[i], fourT[i], 8'h10 + 8'(i));
         txChar(8'hC3 ^ 8'(i), parT[i], hiT[i] ? DHI : DLO);
         rxChar(8'h5A ^ 8'(i), parT[i], hiT[i] ? DHI : DLO, 1'b0, 1'b1);
      end
      $display("test modes done");
      rxChar(8'h81, 2'h1, DLO, 1'b1, 1'b0);
      `SLFC_CHK(rxErr, 1'b1)
      rxChar(8'h42, 2'h1, DLO, 1'b0, 1'b0);
      @(posedge clk);
      errClr <= 1'b1;
      @(posedge clk);
      errClr <= 1'b0;
      repeat ((GAP + 2) * DLO) @(posedge clk);
      #1;
      `SLFC_CHK(rxErr, 1'b0)
      rxChar(8'h24, 2'h1, DLO, 1'b0, 1'b1);
      `SLFC_CHK(gotFirst, 1'b1)
      rxChar(8'h18, 2'h1, DLO, 1'b0, 1'b1);
      `SLFC_CHK(gotFirst, 1'b0)
      $display("test error drop done");
      setCfg(1'b1, 2'h0, 1'b1, 8'h20, 1'b0);
      @(posedge clk);
      clkEn <= 1'b0;
      restartChk(1'b0, 2'h1, 1'b0, 8'h13);
      @(posedge clk);
      clkEn <= 1'b1;
      restartChk(1'b1, 2'h0, 1'b1, 8'h20);
      $display("test clock enable done");
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule : slfc_serial_port_tb
